// File: eoc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module eoc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             en,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             ready_q;
    logic             push;
    logic             pop;

    // ready is a flop so the top output comes straight from a register
    assign in_ready  = ready_q;
    assign cnt_d     = (push && !pop) ? cnt_q + 1'b1 :
                       (pop && !push) ? cnt_q - 1'b1 : cnt_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = en && in_valid && in_ready;
    assign pop       = en && out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
        end else begin
            ready_q <= (cnt_d != (AW+1)'(DEPTH));
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: eoc_map.svh
`ifndef EOC_MAP_SVH
`define EOC_MAP_SVH
`define EOC_MSG_W        12
`define EOC_ADDR_HI      11
`define EOC_ADDR_LO      9
`define EOC_DM_BIT       8
`define EOC_INFO_HI      7
`define EOC_ADDR_NT      3'h0
`define EOC_ADDR_BCAST   3'h7
`define EOC_CODE_HOLD    8'h00
`define EOC_CODE_FULLLB  8'h50
`define EOC_CODE_B1LB    8'h51
`define EOC_CODE_B2LB    8'h52
`define EOC_CODE_RCC     8'h53
`define EOC_CODE_NCC     8'h54
`define EOC_CODE_UTC     8'hAA
`define EOC_CODE_RTN     8'hFF
`define EOC_TX_RESET     12'h1FF
`define EOC_HOLD_MSG     12'h100
`define EOC_MATCH_COUNT  2'h3
`define EOC_DM0_LIMIT    2'h3
`define EOC_FIFO_DEPTH   32
`endif

// File: eoc_match.sv
`timescale 1ns/1ns
`default_nettype none
`include "eoc_map.svh"
module eoc_match #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             en,
    // message in
    input  wire logic             msg_valid,
    input  wire logic [WIDTH-1:0] msg,
    // verdicts, valid with msg_valid
    output logic                  changed,
    output logic                  verified_new
);
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] ver_q;
    logic [1:0]       run_q;
    logic [1:0]       run_d;

    // run counter saturates; the ver_q compare makes a steady message verify only once
    assign run_d        = (msg != prev_q) ? 2'h1 :
                          (run_q == `EOC_MATCH_COUNT) ? run_q : run_q + 2'h1;
    assign changed      = (msg != prev_q);
    assign verified_new = (run_d == `EOC_MATCH_COUNT) && (msg != ver_q);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= `EOC_TX_RESET;
            ver_q  <= `EOC_TX_RESET;
            run_q  <= 2'h0;
        end else if (en && msg_valid) begin
            prev_q <= msg;
            run_q  <= run_d;
            if (verified_new) begin
                ver_q <= msg;
            end
        end
    end
endmodule
`default_nettype wire

// File: eoc_message_processor.sv
// Operation
// - answer hold when address is foreign or data/message bit is zero for the first or second time in a row
// - full loopback command in auto mode raises loop request indication
// - b1 loop command loops b1 and sets b1 loop and side select
// - b2 loop command loops b2 and sets b2 loop and side select
// - request corrupt crc inverts crc, stops far-end counter, holds indications
// - notify corrupt crc disables near-end counters and holds indications
// - undefined command, or zero data/message bit from the third in a row, answers unable to comply
// - return to normal releases latches and resets tx register to 1FF
// - defined, correctly addressed command is echoed back unchanged
// - auto mode echoes at once; foreign address gets hold at address 000
// - auto mode sends unable to comply from the third zero d/m reception in a row
// - auto mode latches commands in parallel until return or deactivation
// - auto mode interrupts on new triple-matched message, any address
// - auto mode executes only addressed, d/m one, triple-matched commands
// - periodic mode reports every received frame each 6 ms
// - transparent modes transmit the code last written by software
// - transparent modes neither latch nor execute commands
// - on-change mode interrupts only when the message changed
// - triple mode interrupts after three consecutive equal messages
// - message is three address bits, d/m bit, eight information bits
// - interrupt only after the receive register has been updated
`timescale 1ns/1ns
`default_nettype none
`include "eoc_map.svh"
module eoc_message_processor #(
    parameter int WIDTH = `EOC_MSG_W,
    parameter int DEPTH = `EOC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               en,
    // configuration
    input  wire eoc_pkg::eoc_mode_type mode,
    input  wire logic               deactivate,
    // received frames from the deframer, one per 6 ms
    input  wire logic               rx_valid,
    output logic                    rx_ready,
    input  wire logic [WIDTH-1:0]   rx_msg,
    // outgoing frame request from the framer
    input  wire logic               tx_strobe,
    output logic [WIDTH-1:0]        tx_msg,
    // software transmit write
    input  wire logic               tx_wr,
    input  wire logic [WIDTH-1:0]   tx_wr_data,
    // software view
    output logic [WIDTH-1:0]        ops_chan_rx_reg,
    output logic [WIDTH-1:0]        ops_chan_tx_reg,
    output logic                    eoc_irq,
    // command outputs
    output logic                    loop_request_indication,
    output logic                    b1_loop,
    output logic                    b2_loop,
    output logic                    loop_side_select,
    output logic                    crc_invert,
    output logic                    far_cnt_stop,
    output logic                    near_cnt_stop,
    output logic                    err_hold
);
    import eoc_pkg::*;

    function automatic logic is_defined(input logic [7:0] c);
        is_defined = (c == `EOC_CODE_HOLD) || (c == `EOC_CODE_FULLLB) ||
                     (c == `EOC_CODE_B1LB) || (c == `EOC_CODE_B2LB) ||
                     (c == `EOC_CODE_RCC) || (c == `EOC_CODE_NCC) ||
                     (c == `EOC_CODE_RTN);
    endfunction

    function automatic logic addr_ok(input logic [2:0] a);
        addr_ok = (a == `EOC_ADDR_NT) || (a == `EOC_ADDR_BCAST);
    endfunction

    logic [WIDTH-1:0] f_data;
    logic             f_valid;
    logic             f_pop;
    logic [WIDTH-1:0] msg_q;
    logic             changed_q;
    logic             verified_q;
    logic             changed;
    logic             verified_new;
    logic [1:0]       dm0_cnt_q;
    logic [WIDTH-1:0] sw_tx_q;
    logic [WIDTH-1:0] auto_tx_q;
    proc_state_type   state_q;
    logic [2:0]       m_addr;
    logic             m_dm;
    logic [7:0]       m_info;
    logic             m_exec;

    eoc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .en        (en),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_msg),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    eoc_match #(.WIDTH(WIDTH)) u_match (
        .clk          (clk),
        .rst_b        (rst_b),
        .en           (en),
        .msg_valid    (f_pop),
        .msg          (f_data),
        .changed      (changed),
        .verified_new (verified_new)
    );

    // one message per three-cycle pass keeps echo and report ordered
    assign f_pop  = f_valid && (state_q == st_idle);
    assign m_addr = msg_q[`EOC_ADDR_HI:`EOC_ADDR_LO];
    assign m_dm   = msg_q[`EOC_DM_BIT];
    assign m_info = msg_q[`EOC_INFO_HI:0];
    assign m_exec = (mode == mode_auto) && verified_q && addr_ok(m_addr) && m_dm;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= st_idle;
            msg_q      <= '0;
            changed_q  <= 1'b0;
            verified_q <= 1'b0;
        end else if (en) begin
            case (state_q)
                st_idle: begin
                    if (f_pop) begin
                        msg_q      <= f_data;
                        changed_q  <= changed;
                        verified_q <= verified_new;
                        state_q    <= st_decide;
                    end
                end
                st_decide: state_q <= st_report;
                st_report: state_q <= st_idle;
                default:   state_q <= st_idle;
            endcase
        end
    end

    // receive register loads in decide; interrupt follows one cycle later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ops_chan_rx_reg <= `EOC_TX_RESET;
        end else if (en && state_q == st_decide) begin
            ops_chan_rx_reg <= msg_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            eoc_irq <= 1'b0;
        end else if (en) begin
            eoc_irq <= 1'b0;
            if (state_q == st_report) begin
                case (mode)
                    mode_auto:     eoc_irq <= verified_q;
                    mode_periodic: eoc_irq <= 1'b1;
                    mode_change:   eoc_irq <= changed_q;
                    mode_triple:   eoc_irq <= verified_q;
                    default:       eoc_irq <= 1'b0;
                endcase
            end
        end
    end

    // zero d/m run counter for the unable-to-comply exception
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dm0_cnt_q <= 2'h0;
        end else if (en && state_q == st_decide) begin
            if (m_dm || !addr_ok(m_addr)) begin
                dm0_cnt_q <= 2'h0;
            end else if (dm0_cnt_q != `EOC_DM0_LIMIT) begin
                dm0_cnt_q <= dm0_cnt_q + 2'h1;
            end
        end
    end

    // auto answer chosen at once, no triple match needed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            auto_tx_q <= `EOC_TX_RESET;
        end else if (en && state_q == st_decide) begin
            if (!addr_ok(m_addr)) begin
                auto_tx_q <= `EOC_HOLD_MSG;
            end else if (!m_dm) begin
                // first two zero d/m answer hold, the third unable to comply
                if (dm0_cnt_q >= `EOC_DM0_LIMIT - 2'h1) begin
                    auto_tx_q <= {m_addr, 1'b1, `EOC_CODE_UTC};
                end else begin
                    auto_tx_q <= {m_addr, 1'b1, `EOC_CODE_HOLD};
                end
            end else if (!is_defined(m_info)) begin
                auto_tx_q <= {m_addr, 1'b1, `EOC_CODE_UTC};
            end else if (m_info == `EOC_CODE_RTN && verified_q) begin
                auto_tx_q <= `EOC_TX_RESET;
            end else begin
                auto_tx_q <= msg_q;
            end
        end
    end

    // software transmit value; last write wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_tx_q <= `EOC_TX_RESET;
        end else if (en) begin
            if (tx_wr) begin
                sw_tx_q <= tx_wr_data;
            end else if (state_q == st_decide && m_exec && m_info == `EOC_CODE_RTN) begin
                sw_tx_q <= `EOC_TX_RESET;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ops_chan_tx_reg <= `EOC_TX_RESET;
        end else if (en) begin
            ops_chan_tx_reg <= (mode == mode_auto) ? auto_tx_q : sw_tx_q;
        end
    end

    // value frozen per outgoing frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_msg <= `EOC_TX_RESET;
        end else if (en && tx_strobe) begin
            tx_msg <= ops_chan_tx_reg;
        end
    end

    // latched commands run in parallel; transparent modes drop them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loop_request_indication <= 1'b0;
            b1_loop                 <= 1'b0;
            b2_loop                 <= 1'b0;
            loop_side_select        <= 1'b0;
            crc_invert              <= 1'b0;
            far_cnt_stop            <= 1'b0;
            near_cnt_stop           <= 1'b0;
            err_hold                <= 1'b0;
        end else if (en) begin
            if (deactivate || mode != mode_auto) begin
                loop_request_indication <= 1'b0;
                b1_loop                 <= 1'b0;
                b2_loop                 <= 1'b0;
                loop_side_select        <= 1'b0;
                crc_invert              <= 1'b0;
                far_cnt_stop            <= 1'b0;
                near_cnt_stop           <= 1'b0;
                err_hold                <= 1'b0;
            end else if (state_q == st_decide && m_exec) begin
                case (m_info)
                    `EOC_CODE_FULLLB: loop_request_indication <= 1'b1;
                    `EOC_CODE_B1LB: begin
                        b1_loop          <= 1'b1;
                        loop_side_select <= 1'b1;
                    end
                    `EOC_CODE_B2LB: begin
                        b2_loop          <= 1'b1;
                        loop_side_select <= 1'b1;
                    end
                    `EOC_CODE_RCC: begin
                        crc_invert   <= 1'b1;
                        far_cnt_stop <= 1'b1;
                        err_hold     <= 1'b1;
                    end
                    `EOC_CODE_NCC: begin
                        near_cnt_stop <= 1'b1;
                        err_hold      <= 1'b1;
                    end
                    `EOC_CODE_RTN: begin
                        loop_request_indication <= 1'b0;
                        b1_loop                 <= 1'b0;
                        b2_loop                 <= 1'b0;
                        loop_side_select        <= 1'b0;
                        crc_invert              <= 1'b0;
                        far_cnt_stop            <= 1'b0;
                        near_cnt_stop           <= 1'b0;
                        err_hold                <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end

    chk_irq_after_load: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(eoc_irq) |-> $past(state_q) == st_report)
        else $error("interrupt without preceding register load");
    chk_periodic_report: assert property (@(posedge clk) disable iff (!rst_b)
        (en && state_q == st_report && mode == mode_periodic) |=> eoc_irq)
        else $error("periodic frame not reported");
    chk_change_only: assert property (@(posedge clk) disable iff (!rst_b)
        (en && state_q == st_report && mode == mode_change && !changed_q) |=> !eoc_irq)
        else $error("on-change interrupt without change");
    chk_triple_only: assert property (@(posedge clk) disable iff (!rst_b)
        (en && state_q == st_report && mode == mode_triple && !verified_q) |=> !eoc_irq)
        else $error("triple interrupt without match");
    chk_no_latch_transp: assert property (@(posedge clk) disable iff (!rst_b)
        (en && mode != mode_auto) |=> !b1_loop && !b2_loop && !crc_invert)
        else $error("command latched in transparent mode");
    chk_b1_exec: assert property (@(posedge clk) disable iff (!rst_b)
        (en && state_q == st_decide && m_exec && m_info == `EOC_CODE_B1LB && !deactivate)
        |=> b1_loop && loop_side_select)
        else $error("b1 loop not closed");
    chk_foreign_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (en && state_q == st_decide && !addr_ok(m_addr)) |=> auto_tx_q == `EOC_HOLD_MSG)
        else $error("foreign address not answered with hold");
    chk_sw_tx: assert property (@(posedge clk) disable iff (!rst_b)
        (en && tx_wr && mode != mode_auto) |=> ##1 (!en || ops_chan_tx_reg == $past(tx_wr_data, 2)))
        else $error("transparent tx not software value");
    chk_rcc_exec: assert property (@(posedge clk) disable iff (!rst_b)
        (en && state_q == st_decide && m_exec && m_info == `EOC_CODE_RCC && !deactivate)
        |=> crc_invert && far_cnt_stop && err_hold)
        else $error("corrupt crc request not executed");
    cov_b1_loop: cover property (@(posedge clk) $rose(b1_loop));
    cov_periodic: cover property (@(posedge clk) eoc_irq && mode == mode_periodic);
    cov_utc: cover property (@(posedge clk) auto_tx_q[7:0] == `EOC_CODE_UTC);
    cov_fifo_full: cover property (@(posedge clk) !rx_ready);
endmodule
`default_nettype wire

// File: eoc_pkg.sv
package eoc_pkg;
    typedef enum logic [1:0] {
        mode_auto     = 2'b00,
        mode_periodic = 2'b01,
        mode_change   = 2'b10,
        mode_triple   = 2'b11
    } eoc_mode_type;
    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_decide = 2'b01,
        st_report = 2'b10
    } proc_state_type;
endpackage

// File: lt_model.sv
`timescale 1ns/1ns
`default_nettype none
module lt_model (
    // clock
    input  wire logic   clk,
    // received words toward the block
    output logic        rx_valid,
    input  wire logic   rx_ready,
    output logic [11:0] rx_msg,
    // frame timing
    output logic        tx_strobe
);
    initial begin
        rx_valid = 1'b0;
        rx_msg = 12'h000;
        tx_strobe = 1'b0;
    end
    // word is held until the edge that sees ready
    task automatic send(input logic [11:0] m);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_msg = m;
        while (rx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
    // released word is scrambled so stale data never looks valid
    task automatic idle();
        @(negedge clk);
        rx_valid = 1'b0;
        rx_msg = ~rx_msg;
    endtask
    task automatic frame();
        @(negedge clk);
        tx_strobe = 1'b1;
        @(negedge clk);
        tx_strobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import eoc_pkg::*;
    logic         clk;
    logic         rst_b;
    logic         en;
    eoc_mode_type mode;
    logic         deactivate;
    logic         rx_valid;
    logic         rx_ready;
    logic [11:0]  rx_msg;
    logic         tx_strobe;
    logic [11:0]  tx_msg;
    logic         tx_wr;
    logic [11:0]  tx_wr_data;
    logic [11:0]  rx_reg;
    logic [11:0]  tx_reg;
    logic         eoc_irq;
    wire  [7:0]   cmds;
    int           mismatches;
    int           checks_done;
    int           irq_n;
    logic         saw_full;
    logic [15:0]  seed;

    eoc_message_processor #(.WIDTH(12), .DEPTH(32)) dut (
        .clk(clk), .rst_b(rst_b), .en(en), .mode(mode), .deactivate(deactivate),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_msg(rx_msg), .tx_strobe(tx_strobe),
        .tx_msg(tx_msg), .tx_wr(tx_wr), .tx_wr_data(tx_wr_data), .ops_chan_rx_reg(rx_reg),
        .ops_chan_tx_reg(tx_reg), .eoc_irq(eoc_irq), .loop_request_indication(cmds[7]),
        .b1_loop(cmds[6]), .b2_loop(cmds[5]), .loop_side_select(cmds[4]),
        .crc_invert(cmds[3]), .far_cnt_stop(cmds[2]), .near_cnt_stop(cmds[1]),
        .err_hold(cmds[0]));
    lt_model lt (.clk(clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_msg(rx_msg),
        .tx_strobe(tx_strobe));

    always #4 clk = ~clk;
    // irq is a one-cycle pulse, so it is counted rather than polled
    always @(posedge clk) begin
        if (eoc_irq === 1'b1) irq_n++;
        if (rx_valid === 1'b1 && rx_ready === 1'b0) saw_full = 1'b1;
    end

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // 8 cycles covers the pop, decide and report steps
    task automatic snd(input logic [11:0] m);
        lt.send(m);
        lt.idle();
        repeat (8) @(negedge clk);
    endtask
    function automatic logic [11:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed[11:0];
    endfunction
    function automatic logic [11:0] cmd_bits(input logic [7:0] code);
        case (code)
            8'h50: return 12'h080;
            8'h51: return 12'h050;
            8'h52: return 12'h030;
            8'h53: return 12'h00D;
            8'h54: return 12'h003;
            default: return 12'h000;
        endcase
    endfunction

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        logic [11:0] m;
        logic [11:0] prev;
        logic [11:0] exp_c;
        int n0;
        clk = 1'b0; rst_b = 1'b0; en = 1'b1; mode = mode_auto; deactivate = 1'b0;
        tx_wr = 1'b0; tx_wr_data = 12'h000; mismatches = 0; checks_done = 0; irq_n = 0;
        saw_full = 1'b0; seed = 16'h0056; exp_c = 12'h000;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check("tx reset", tx_reg, 12'h1FF);
        for (int c = 0; c < 5; c++) begin
            m = {(c == 2) ? 3'h7 : 3'h0, 1'b1, 8'h50 + 8'(c)};
            n0 = irq_n;
            for (int k = 0; k < 3; k++) begin
                snd(m);
                if (k == 1) check("cmds early", {4'h0, cmds}, exp_c);
                check("echo", tx_reg, m);
            end
            exp_c |= cmd_bits(m[7:0]);
            check("cmds", {4'h0, cmds}, exp_c);
            check("irq cmd", 12'(irq_n - n0), 12'h001);
        end
        lt.frame();
        repeat (2) @(negedge clk);
        check("tx frame", tx_msg, m);
        n0 = irq_n;
        repeat (3) snd(12'h350);
        check("hold", tx_reg, 12'h100);
        check("irq foreign", 12'(irq_n - n0), 12'h001);
        check("cmds foreign", {4'h0, cmds}, exp_c);
        snd(12'h1AB);
        check("undefined", {4'h0, tx_reg[7:0]}, 12'h0AA);
        for (int k = 0; k < 3; k++) begin
            snd(12'h054);
            check("dm zero", {4'h0, tx_reg[7:0]}, (k == 2) ? 12'h0AA : 12'h000);
        end
        check("cmds dm zero", {4'h0, cmds}, exp_c);
        deactivate = 1'b1;
        repeat (4) @(negedge clk);
        deactivate = 1'b0;
        check("deactivate", {4'h0, cmds}, 12'h000);
        repeat (3) snd(12'h150);
        check("relatch", {4'h0, cmds}, 12'h080);
        repeat (3) snd(12'h1FF);
        check("release", {4'h0, cmds}, 12'h000);
        check("tx release", tx_reg, 12'h1FF);
        mode = mode_periodic;
        n0 = irq_n;
        repeat (2) snd(12'h123);
        check("irq periodic", 12'(irq_n - n0), 12'h002);
        check("rx reg", rx_reg, 12'h123);
        tx_wr = 1'b1;
        tx_wr_data = 12'h2C5;
        @(negedge clk);
        tx_wr = 1'b0;
        lt.frame();
        repeat (2) @(negedge clk);
        check("tx software", tx_msg, 12'h2C5);
        // enable low must swallow both the write and the frame strobe
        en = 1'b0;
        tx_wr = 1'b1;
        tx_wr_data = 12'h3A5;
        lt.frame();
        tx_wr = 1'b0;
        en = 1'b1;
        repeat (2) @(negedge clk);
        check("en frozen frame", tx_msg, 12'h2C5);
        check("en frozen write", tx_reg, 12'h2C5);
        mode = mode_triple;
        n0 = irq_n;
        repeat (4) snd(12'h150);
        check("irq triple", 12'(irq_n - n0), 12'h001);
        check("no execute", {4'h0, cmds}, 12'h000);
        mode = mode_change;
        prev = 12'h150;
        for (int i = 0; i < 24; i++) begin
            m = (i % 4 == 3) ? prev : rnd();
            n0 = irq_n;
            snd(m);
            check("irq change", 12'(irq_n - n0), (m !== prev) ? 12'h001 : 12'h000);
            check("rx reg", rx_reg, m);
            prev = m;
        end
        // pushes outrun the one-per-three pop rate, so the fifo must refuse
        n0 = irq_n;
        for (int i = 0; i < 60; i++) lt.send((i % 2 == 1) ? prev ^ 12'h001 : prev ^ 12'h002);
        lt.idle();
        repeat (250) @(negedge clk);
        check("irq burst", 12'(irq_n - n0), 12'h03C);
        check("fifo refused", {11'h0, saw_full}, 12'h001);
        check("fifo drained", {11'h0, rx_ready}, 12'h001);
        wrap_up();
    end
endmodule
`default_nettype wire
